// ### bmdma_pkg.sv
// Constants shared by the banked data memory addressing unit
package bmdma_pkg;
    localparam int DW  = 8;
    localparam int AW  = 8;
    localparam int EAW = 9;
    localparam int PCW = 13;
    localparam int TWW = 16;
    localparam int RAM_DEPTH = 256;
    localparam int RAM_AW    = 8;

    localparam logic [7:0] ADDR_PORT0   = 8'h00;
    localparam logic [7:0] ADDR_PTR0    = 8'h01;
    localparam logic [7:0] ADDR_PORT1   = 8'h02;
    localparam logic [7:0] ADDR_PTR1    = 8'h03;
    localparam logic [7:0] ADDR_BANKSEL = 8'h04;
    localparam logic [7:0] ADDR_PCLOW   = 8'h06;
    localparam logic [7:0] ADDR_TBLPLO  = 8'h07;
    localparam logic [7:0] ADDR_TBLHIGH = 8'h08;
    localparam logic [7:0] ADDR_TBLPHI  = 8'h09;
    localparam logic [7:0] ADDR_NVMCTL  = 8'h40;
    localparam logic [7:0] GPR_BASE     = 8'h80;

    localparam int         GPR_BIT       = 7;
    localparam int         BANK_BIT      = 0;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [7:0] BANKSEL_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET     = 8'h00;
    localparam logic [7:0] TBL_RESET     = 8'h00;
    localparam logic [7:0] ONE_BYTE      = 8'h01;

    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_BSET  = 3'h2,
        OP_BCLR  = 3'h3,
        OP_INC   = 3'h4,
        OP_DEC   = 3'h5
    } bmdma_op_t;
endpackage : bmdma_pkg

// ### bmdma_addr_resolve.sv
// Effective address former for direct and indirect data memory access
module bmdma_addr_resolve
    import bmdma_pkg::*;
(
    input  wire logic [AW-1:0]  reqAddr,
    input  wire logic           bankSel,
    input  wire logic [AW-1:0]  ptrZero,
    input  wire logic [AW-1:0]  ptrOne,
    output logic      [EAW-1:0] effAddr,
    output logic                viaPort,
    output logic                selfRef
);
    logic          isPort0;
    logic          isPort1;
    logic [AW-1:0] target;

    assign isPort0 = (reqAddr == ADDR_PORT0);
    assign isPort1 = (reqAddr == ADDR_PORT1);
    assign viaPort = isPort0 | isPort1; // RQ5
    // Port zero stays in bank 0, port one follows the bank choice bit
    assign effAddr = isPort0 ? {1'b0, ptrZero} :     // RQ6
                     isPort1 ? {bankSel, ptrOne} :   // RQ19
                               {1'b0, reqAddr};      // RQ9
    assign target  = effAddr[AW-1:0];
    assign selfRef = viaPort &&
                     (target == ADDR_PORT0 || target == ADDR_PORT1); // RQ7
endmodule : bmdma_addr_resolve

// ### bmdma_gpr_ram.sv
// General purpose RAM, both banks in one array
module bmdma_gpr_ram
    import bmdma_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [RAM_AW-1:0] addr,
    input  wire logic              wrEn,
    input  wire logic [DW-1:0]     wrData,
    output logic      [DW-1:0]     rdData
);
    logic [DW-1:0] mem [RAM_DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= wrData; // RQ2
        end
    end

    assign rdData = mem[addr];
endmodule : bmdma_gpr_ram

// ### bmdma_data_mem.sv
// Banked data memory addressing unit: SFR map, pointers, banks, RAM
// Operation
// RQ1: SFRs everywhere; nvm control only bank 1
// RQ2: 256 bytes GPR, 80H-FFH per bank
// RQ3: unused SFR locations read 00H
// RQ4: protected SFRs ignore program writes
// RQ5: port access acts on pointed location
// RQ6: port zero bank 0; port one chosen bank
// RQ7: port reaching a port reads 00H, no write
// RQ8: pointers are plain read/write storage
// RQ9: direct addressing always reaches bank 0
// RQ10: bank bit 0 selects; bits 7-1 zero
// RQ11: reset selects bank 0 unless sleep watchdog
// RQ12: PC low write jumps within page
// RQ13: PC low load inserts one dummy cycle
// RQ14: table read fills high byte and destination
// RQ15: table pointers read/write, increment, decrement
// RQ16: software loads table pointers before reads
// RQ17: bit set/clear keeps other bits
// RQ18: no memory-to-memory move; via accumulator
// RQ19: port one address is bank bit, pointer
// RQ20: table high byte treated read-only by software
module bmdma_data_mem
    import bmdma_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           wdtSleepReset,
    input  wire logic           reqValid,
    input  wire logic [2:0]     reqOp,
    input  wire logic [AW-1:0]  reqAddr,
    input  wire logic [DW-1:0]  reqWdata,
    input  wire logic [2:0]     reqBitSel,
    output logic                respValid,
    output logic      [DW-1:0]  respData,
    input  wire logic           tblValid,
    input  wire logic [TWW-1:0] tblWord,
    input  wire logic [AW-1:0]  tblDest,
    output logic      [TWW-1:0] tablePointer,
    input  wire logic [PCW-1:0] pcCurrent,
    output logic                pcLoad,
    output logic      [PCW-1:0] pcTarget,
    output logic                dummyCycle,
    output logic                nvmWrite,
    output logic      [DW-1:0]  nvmWdata,
    input  wire logic [DW-1:0]  nvmRdata,
    output logic                bankSelect
);
    logic [DW-1:0]  ptr0_q;
    logic [DW-1:0]  ptr1_q;
    logic [DW-1:0]  bank_q;
    logic [DW-1:0]  bank_d;
    logic [DW-1:0]  tblpLo_q;
    logic [DW-1:0]  tblpHi_q;
    logic [DW-1:0]  tblHigh_q;
    logic           respValid_q;
    logic [DW-1:0]  respData_q;
    logic           pcLoad_q;
    logic [PCW-1:0] pcTarget_q;
    logic           dummy_q;
    logic           nvmWrite_q;
    logic [DW-1:0]  nvmWdata_q;

    logic           active;
    logic [2:0]     curOp;
    logic [AW-1:0]  curAddr;
    logic [DW-1:0]  curWdata;
    logic [EAW-1:0] effAddr;
    logic           viaPort;
    logic           selfRef;
    logic [AW-1:0]  target;
    logic           tgtBank;
    logic           isGpr;
    logic           isSfr;
    logic           hitPtr0;
    logic           hitPtr1;
    logic           hitBank;
    logic           hitPcLow;
    logic           hitTblpLo;
    logic           hitTblpHi;
    logic           hitTblHigh;
    logic           hitNvm;
    logic           sfrUnused;
    logic [DW-1:0]  sfrRdata;
    logic [DW-1:0]  ramRdata;
    logic [DW-1:0]  curRdata;
    logic [DW-1:0]  bitMask;
    logic [DW-1:0]  newData;
    logic           doWrite;
    logic           ramWe;
    logic [RAM_AW-1:0] ramAddr;

    // A table read completion takes the access path for its low byte
    assign active   = tblValid | reqValid;
    assign curOp    = tblValid ? OP_WRITE : reqOp;
    assign curAddr  = tblValid ? tblDest : reqAddr;
    assign curWdata = tblValid ? tblWord[DW-1:0] : reqWdata; // RQ14

    bmdma_addr_resolve u_resolve (
        .reqAddr (curAddr),
        .bankSel (bank_q[BANK_BIT]),
        .ptrZero (ptr0_q),
        .ptrOne  (ptr1_q),
        .effAddr (effAddr),
        .viaPort (viaPort),
        .selfRef (selfRef)
    );

    assign target  = effAddr[AW-1:0];
    assign tgtBank = effAddr[AW];
    assign isGpr   = target[GPR_BIT] && !selfRef;
    assign isSfr   = !target[GPR_BIT] && !selfRef;

    // SFR decode; the same registers answer in both banks, except nvm control, which answers in bank 1 only
    assign hitPtr0    = isSfr && (target == ADDR_PTR0);    // RQ1
    assign hitPtr1    = isSfr && (target == ADDR_PTR1);
    assign hitBank    = isSfr && (target == ADDR_BANKSEL);
    assign hitPcLow   = isSfr && (target == ADDR_PCLOW);
    assign hitTblpLo  = isSfr && (target == ADDR_TBLPLO);
    assign hitTblpHi  = isSfr && (target == ADDR_TBLPHI);
    assign hitTblHigh = isSfr && (target == ADDR_TBLHIGH);
    assign hitNvm     = isSfr && (target == ADDR_NVMCTL) && tgtBank; // RQ1
    assign sfrUnused  = isSfr && !(hitPtr0 | hitPtr1 | hitBank | hitPcLow |
                        hitTblpLo | hitTblpHi | hitTblHigh | hitNvm);

    assign sfrRdata = hitPtr0    ? ptr0_q :                // RQ8
                      hitPtr1    ? ptr1_q :
                      hitBank    ? bank_q :                // RQ10
                      hitPcLow   ? pcCurrent[DW-1:0] :
                      hitTblpLo  ? tblpLo_q :              // RQ15
                      hitTblpHi  ? tblpHi_q :
                      hitTblHigh ? tblHigh_q :
                      hitNvm     ? nvmRdata :
                                   ZERO_BYTE;              // RQ3

    assign curRdata = selfRef ? ZERO_BYTE :                // RQ7
                      isGpr   ? ramRdata : sfrRdata;

    // Read-modify-write operations; there is no memory-to-memory move
    assign bitMask = ONE_BYTE << reqBitSel;
    always_comb begin
        case (curOp)                                       // RQ18
            OP_WRITE: newData = curWdata;
            OP_BSET:  newData = curRdata | bitMask;        // RQ17
            OP_BCLR:  newData = curRdata & ~bitMask;       // RQ17
            OP_INC:   newData = curRdata + ONE_BYTE;       // RQ15
            OP_DEC:   newData = curRdata - ONE_BYTE;       // RQ15
            default:  newData = curRdata;
        endcase
    end

    assign doWrite = active && (curOp != OP_READ) && !selfRef; // RQ7
    assign ramWe   = doWrite && isGpr;
    assign ramAddr = {tgtBank, target[GPR_BIT-1:0]};       // RQ2

    bmdma_gpr_ram u_ram (
        .clk    (clk),
        .addr   (ramAddr),
        .wrEn   (ramWe),
        .wrData (newData),
        .rdData (ramRdata)
    );

    // Only bank choice bit is storage; upper bits stay zero
    assign bank_d = (doWrite && hitBank) ?
                    {7'h00, newData[BANK_BIT]} : bank_q;   // RQ10

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bank_q <= wdtSleepReset ? bank_q : BANKSEL_RESET; // RQ11
        end else begin
            bank_q <= bank_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr0_q   <= PTR_RESET;
            ptr1_q   <= PTR_RESET;
            tblpLo_q <= TBL_RESET;
            tblpHi_q <= TBL_RESET;
        end else begin
            if (doWrite && hitPtr0) begin
                ptr0_q <= newData;                         // RQ8
            end
            if (doWrite && hitPtr1) begin
                ptr1_q <= newData;                         // RQ8
            end
            if (doWrite && hitTblpLo) begin
                tblpLo_q <= newData;                       // RQ15
            end
            if (doWrite && hitTblpHi) begin
                tblpHi_q <= newData;                       // RQ15
            end
        end
    end

    // High byte register is loaded only by table reads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tblHigh_q <= TBL_RESET;
        end else if (tblValid) begin
            tblHigh_q <= tblWord[TWW-1:DW];                // RQ14 RQ4 RQ20
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcLoad_q   <= 1'b0;
            dummy_q    <= 1'b0;
            pcTarget_q <= '0;
        end else begin
            pcLoad_q <= doWrite && hitPcLow;
            dummy_q  <= doWrite && hitPcLow;               // RQ13
            if (doWrite && hitPcLow) begin
                pcTarget_q <= {pcCurrent[PCW-1:DW], newData}; // RQ12
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvmWrite_q <= 1'b0;
            nvmWdata_q <= ZERO_BYTE;
        end else begin
            nvmWrite_q <= doWrite && hitNvm;               // RQ1
            if (doWrite && hitNvm) begin
                nvmWdata_q <= newData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            respValid_q <= 1'b0;
            respData_q  <= ZERO_BYTE;
        end else begin
            respValid_q <= active;
            if (active) begin
                respData_q <= curRdata;                    // RQ5
            end
        end
    end

    assign respValid    = respValid_q;
    assign respData     = respData_q;
    assign tablePointer = {tblpHi_q, tblpLo_q};            // RQ15
    assign pcLoad       = pcLoad_q;
    assign pcTarget     = pcTarget_q;
    assign dummyCycle   = dummy_q;
    assign nvmWrite     = nvmWrite_q;
    assign nvmWdata     = nvmWdata_q;
    assign bankSelect   = bank_q[BANK_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_unused_zero;
        active && sfrUnused |=> respData == ZERO_BYTE;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // RQ3
        else $error("unused SFR read not zero");

    property p_nvm_bank1;
        active && doWrite && isSfr && (target == ADDR_NVMCTL) && !tgtBank
            |=> !nvmWrite;
    endproperty
    a_nvm_bank1: assert property (p_nvm_bank1) // RQ1
        else $error("nvm control written from bank 0");

    property p_gpr_rw;
        reqValid && !tblValid && reqOp == OP_WRITE && reqAddr[GPR_BIT]
        ##1 reqValid && !tblValid && reqOp == OP_READ &&
            reqAddr == $past(reqAddr)
        |=> respData == $past(reqWdata, 2);
    endproperty
    a_gpr_rw: assert property (p_gpr_rw) // RQ2
        else $error("GPR readback mismatch");

    property p_table_high_byte_ro;
        doWrite && hitTblHigh && !tblValid |=> $stable(tblHigh_q);
    endproperty
    a_table_high_byte_ro: assert property (p_table_high_byte_ro) // RQ4
        else $error("table high byte changed by write");

    property p_self_ref;
        active && selfRef |=> respData == ZERO_BYTE &&
            $stable(ptr0_q) && $stable(ptr1_q) && $stable(bank_q);
    endproperty
    a_self_ref: assert property (p_self_ref) // RQ7
        else $error("port-to-port access had effect");

    property p_port0_bank;
        active && curAddr == ADDR_PORT0 |-> effAddr == {1'b0, ptr0_q};
    endproperty
    a_port0_bank: assert property (p_port0_bank) // RQ6
        else $error("port zero left bank 0");

    property p_port1_addr;
        active && curAddr == ADDR_PORT1 |-> effAddr == {bank_q[BANK_BIT], ptr1_q};
    endproperty
    a_port1_addr: assert property (p_port1_addr) // RQ19
        else $error("port one address wrong");

    property p_direct_bank0;
        active && !viaPort |-> !tgtBank;
    endproperty
    a_direct_bank0: assert property (p_direct_bank0) // RQ9
        else $error("direct access left bank 0");

    property p_bank_upper;
        active && hitBank |=> respData[7:1] == 7'h00;
    endproperty
    a_bank_upper: assert property (p_bank_upper) // RQ10
        else $error("bank register upper bits set");

    property p_bank_reset;
        @(posedge clk) disable iff (1'b0)
        !rst_n && !wdtSleepReset |=> bank_q == BANKSEL_RESET;
    endproperty
    a_bank_reset: assert property (p_bank_reset) // RQ11
        else $error("reset did not select bank 0");

    property p_pc_page;
        doWrite && hitPcLow |=> pcLoad && dummyCycle &&
            pcTarget[PCW-1:DW] == $past(pcCurrent[PCW-1:DW]);
    endproperty
    a_pc_page: assert property (p_pc_page) // RQ12 RQ13
        else $error("PC low load wrong");

    property p_tbl_high;
        tblValid |=> tblHigh_q == $past(tblWord[TWW-1:DW]);
    endproperty
    a_tbl_high: assert property (p_tbl_high) // RQ14
        else $error("table high byte not captured");

    c_port1_bank1: cover property (active && curAddr == ADDR_PORT1 && tgtBank);
    c_nvm_access:  cover property (doWrite && hitNvm);
    c_pc_jump:     cover property (doWrite && hitPcLow);
    c_bit_set:     cover property (active && curOp == OP_BSET && isGpr);
endmodule : bmdma_data_mem

// ### bmdma_core_model.sv
// Behavioural model of the CPU core side: program counter and nvm control register
module bmdma_core_model
    import bmdma_pkg::*;
#(
    parameter logic [PCW-1:0] PC_START = 13'h0000
)(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           pcLoad,
    input  wire logic [PCW-1:0] pcTarget,
    input  wire logic           nvmWrite,
    input  wire logic [DW-1:0]  nvmWdata,
    output logic      [PCW-1:0] pcCurrent,
    output logic      [DW-1:0]  nvmRdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [PCW-1:0] pc_q;
    logic [DW-1:0]  nvm_q;

    // Core follows a page-local jump
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_q <= PC_START;
        end else if (pcLoad) begin
            pc_q <= pcTarget;
        end
    end

    // Control register only changes on a write that reached it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_q <= 8'h00;
        end else if (nvmWrite) begin
            nvm_q <= nvmWdata;
        end
    end

    assign pcCurrent = pc_q;
    assign nvmRdata  = nvm_q;
endmodule : bmdma_core_model

// ### banked_data_memory_addressing_test.sv
// Self-checking testbench of the banked data memory addressing unit
module banked_data_memory_addressing_test;
    import bmdma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [PCW-1:0] PC_START = 13'h1a37;
    localparam int             TIMEOUT  = 3000;
    localparam logic [8:0]     NC       = 9'h000;

    logic clk = 1'b0;
    logic rst_n, wdtSleepReset, reqValid, tblValid, respValid, pcLoad, dummyCycle;
    logic nvmWrite, bankSelect;
    logic [2:0]     reqOp, reqBitSel;
    logic [7:0]     reqAddr, reqWdata, tblDest, respData, nvmWdata, nvmRdata;
    logic [TWW-1:0] tblWord, tablePointer, w;
    logic [PCW-1:0] pcCurrent, pcTarget;
    logic [8:0]     expQ[$];
    logic [PCW-1:0] pcQ[$];
    logic [8:0]     e;
    logic [7:0]     v, v2, r, b, d;
    logic [31:0]    seed = 32'd75962;
    int fails = 0;
    int checked = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    bmdma_data_mem u_dut (
        .clk(clk), .rst_n(rst_n), .wdtSleepReset(wdtSleepReset), .reqValid(reqValid),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqBitSel(reqBitSel),
        .respValid(respValid), .respData(respData), .tblValid(tblValid), .tblWord(tblWord),
        .tblDest(tblDest), .tablePointer(tablePointer), .pcCurrent(pcCurrent),
        .pcLoad(pcLoad), .pcTarget(pcTarget), .dummyCycle(dummyCycle), .nvmWrite(nvmWrite),
        .nvmWdata(nvmWdata), .nvmRdata(nvmRdata), .bankSelect(bankSelect));

    bmdma_core_model #(.PC_START(PC_START)) u_core (
        .clk(clk), .rst_n(rst_n), .pcLoad(pcLoad), .pcTarget(pcTarget), .nvmWrite(nvmWrite),
        .nvmWdata(nvmWdata), .pcCurrent(pcCurrent), .nvmRdata(nvmRdata));

    function logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd8

    function automatic logic [8:0] ck(input logic [7:0] x);
        return {1'b1, x};
    endfunction : ck

    task automatic chk(input logic [TWW-1:0] seen, input logic [TWW-1:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic rq(input logic [2:0] op, input logic [7:0] a, input logic [7:0] dat,
                      input logic [2:0] bit_i, input logic [8:0] ex);
        reqValid = 1'b1;
        reqOp = op;
        reqAddr = a;
        reqWdata = dat;
        reqBitSel = bit_i;
        expQ.push_back(ex);
        @(posedge clk);
        #2;
    endtask : rq

    task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [8:0] ex);
        rq(OP_WRITE, a, dat, 3'h0, ex);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        rq(OP_READ, a, 8'h00, 3'h0, ck(ex));
    endtask : rd

    task automatic idle();
        reqValid = 1'b0;
        @(posedge clk);
        #2;
    endtask : idle

    task automatic done(input string n);
        idle();
        repeat (2) @(posedge clk);
        #2;
        $display("test %s done", n);
    endtask : done

    task automatic rst(input logic wdt, input int n);
        rst_n = 1'b0;
        wdtSleepReset = wdt;
        repeat (n) @(posedge clk);
        #2;
        rst_n = 1'b1;
        wdtSleepReset = 1'b0;
    endtask : rst

    task automatic end_sim();
        chk(16'(expQ.size() + pcQ.size()), 16'h0, "notes left unanswered");
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Every answer is matched against the oldest note of the driver
    always @(negedge clk) begin
        if (respValid === 1'b1) begin
            if (expQ.size() == 0) chk(16'h1, 16'h0, "answer without request");
            else begin
                e = expQ.pop_front();
                if (e[8]) chk(16'(respData), 16'(e[7:0]), "respData");
            end
        end
        if (pcLoad === 1'b1 || dummyCycle === 1'b1) begin
            chk(16'(dummyCycle), 16'h1, "dummy cycle");
            chk(16'(pcLoad), 16'h1, "pc load");
            if (pcQ.size() == 0) chk(16'h1, 16'h0, "unexpected pc load");
            else chk(16'(pcTarget), 16'(pcQ.pop_front()), "pc target");
        end
        cycles++;
        if (cycles > TIMEOUT) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        {reqValid, reqOp, reqAddr, reqWdata, reqBitSel} = '0;
        {tblValid, tblWord, tblDest} = '0;
        rst(1'b0, 16);
        chk(16'(bankSelect), 16'h0, "bank after reset");
        chk(tablePointer, 16'h0, "table ptr after reset");
        v = rnd8();
        v2 = rnd8();
        wr(ADDR_PTR0, 8'h85, ck(PTR_RESET));
        rd(ADDR_PTR0, 8'h85);
        wr(8'h85, v, NC);
        rd(8'h85, v);
        rd(ADDR_PORT0, v);
        wr(ADDR_BANKSEL, 8'hff, ck(BANKSEL_RESET));
        rd(ADDR_BANKSEL, 8'h01);
        wr(ADDR_PTR1, 8'h85, ck(PTR_RESET));
        wr(ADDR_PORT1, v2, NC);
        rd(ADDR_PORT1, v2);
        rd(8'h85, v);
        rd(ADDR_PORT0, v);
        chk(16'(bankSelect), 16'h1, "bank select");
        wr(ADDR_BANKSEL, 8'h00, NC);
        rd(ADDR_PORT1, v);
        done("banks and pointers");
        r = v;
        for (int i = 0; i < 4; i++) begin
            b = rnd8();
            rq(OP_BSET, 8'h85, 8'h00, b[2:0], ck(r));
            r = r | (8'h01 << b[2:0]);
            rq(OP_BCLR, 8'h85, 8'h00, b[5:3], ck(r));
            r = r & ~(8'h01 << b[5:3]);
        end
        rd(8'h85, r);
        done("bit operations");
        wr(ADDR_TBLPLO, 8'hff, ck(TBL_RESET));
        rq(OP_INC, ADDR_TBLPLO, 8'h00, 3'h0, ck(8'hff));
        rd(ADDR_TBLPLO, 8'h00);
        rq(OP_DEC, ADDR_TBLPLO, 8'h00, 3'h0, ck(8'h00));
        rd(ADDR_TBLPLO, 8'hff);
        wr(ADDR_TBLPHI, 8'h1f, ck(TBL_RESET));
        rq(OP_INC, ADDR_TBLPHI, 8'h00, 3'h0, ck(8'h1f));
        done("table pointers");
        chk(tablePointer, 16'h20ff, "table pointer");
        w = {rnd8(), rnd8()};
        {reqValid, reqOp, reqAddr, reqWdata} = {1'b1, OP_WRITE, ADDR_PTR0, 8'h33};
        {tblValid, tblWord, tblDest} = {1'b1, w, 8'h90};
        expQ.push_back(NC);
        @(posedge clk);
        #2;
        {tblValid, reqValid} = 2'b00;
        @(posedge clk);
        #2;
        rd(8'h90, w[7:0]);
        rd(ADDR_TBLHIGH, w[15:8]);
        wr(ADDR_TBLHIGH, ~w[15:8], ck(w[15:8]));
        rd(ADDR_TBLHIGH, w[15:8]);
        rd(ADDR_PTR0, 8'h85);
        done("table read");
        for (int i = 0; i < 8; i++) begin
            d = (i < 4) ? (8'h0a + 8'(i)) : (8'h7f - 8'(i));
            wr(d, 8'hff, ck(ZERO_BYTE));
            rd(d, ZERO_BYTE);
        end
        wr(ADDR_PTR1, ADDR_PORT1, NC);
        rd(ADDR_PORT1, ZERO_BYTE);
        wr(ADDR_PORT1, 8'haa, ck(ZERO_BYTE));
        rd(ADDR_PTR1, ADDR_PORT1);
        wr(ADDR_PTR0, ADDR_PORT0, NC);
        rd(ADDR_PORT0, ZERO_BYTE);
        done("unused and self reference");
        wr(ADDR_BANKSEL, 8'h01, NC);
        wr(ADDR_PTR1, ADDR_NVMCTL, NC);
        wr(ADDR_PORT1, 8'h0b, NC);
        idle();
        rd(ADDR_PORT1, 8'h0b);
        rd(ADDR_NVMCTL, ZERO_BYTE);
        wr(ADDR_BANKSEL, 8'h00, NC);
        wr(ADDR_PORT1, 8'h0e, NC);
        idle();
        rd(ADDR_PORT1, ZERO_BYTE);
        wr(ADDR_BANKSEL, 8'h01, NC);
        rd(ADDR_PORT1, 8'h0b);
        done("nvm control");
        for (int i = 0; i < 2; i++) begin
            d = rnd8();
            pcQ.push_back({PC_START[12:8], d});
            wr(ADDR_PCLOW, d, NC);
        end
        done("pc low");
        rst(1'b1, 2);
        chk(16'(bankSelect), 16'h1, "bank kept on sleep watchdog");
        rst(1'b0, 2);
        chk(16'(bankSelect), 16'h0, "bank after reset");
        rd(ADDR_BANKSEL, 8'h00);
        done("reset");
        end_sim();
    end
endmodule : banked_data_memory_addressing_test
